//--- shared/irq_regs.svh
// Register offsets, field positions, reset values and timing counts of the interrupt handler
`ifndef IRQ_REGS_SVH
`define IRQ_REGS_SVH
`define IRQ_EN_OFS 8'hA8
`define IRQ_HWF_OFS 8'hA9
`define IRQ_STS_OFS 8'hD0
`define IRQ_CLR_OFS 8'hD1
`define IRQ_MSK_OFS 8'hD2
`define IRQ_EN_RST 8'h00
`define IRQ_EN_GLOBAL_BIT 7
`define IRQ_EN_SWFLAG_BIT 6
`define IRQ_EN_SRC_MSB 5
`define IRQ_HWF_RST 4'h0
`define IRQ_EVT_RST 3'h0
`define IRQ_EVT_CALL_BIT 0
`define IRQ_EVT_PREEMPT_BIT 1
`define IRQ_EVT_RETURN_BIT 2
`define IRQ_RESET_VECTOR 16'h0000
`define IRQ_VECTOR_BASE 16'h0003
`define IRQ_VECTOR_LAST 16'h005B
`define IRQ_HW_CLEARED_LAST 4'h3
`define IRQ_DETECT_CYCLES 1
`define IRQ_CALL_CYCLES 4
`define IRQ_RETURN_CYCLES 5
`define IRQ_DIVIDE_CYCLES 8
`define IRQ_MIN_RESPONSE (`IRQ_DETECT_CYCLES + `IRQ_CALL_CYCLES)
`define IRQ_MAX_RESPONSE (`IRQ_DETECT_CYCLES + `IRQ_RETURN_CYCLES + `IRQ_DIVIDE_CYCLES + `IRQ_CALL_CYCLES)
`endif

//--- shared/irq_pkg.sv
// Types and shared functions of the interrupt handler
package irq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CALL = 3'b010,
    ST_HOLD = 3'b100
  } ctl_state_t;

  // Vector of source idx: base plus eight bytes per source
  function automatic logic [15:0] vector_of(input logic [3:0] idx);
    vector_of = 16'h0003 + {9'h000, idx, 3'b000};
  endfunction
endpackage

//--- shared/irq_arb_if.sv
// Carrier between the handler and its priority encoder
interface irq_arb_if;
  logic [11:0] req;
  logic [11:0] prio;
  logic allow_lo;
  logic allow_hi;
  logic win_v;
  logic win_hi;
  logic [3:0] win_idx;
  modport enc (input req, prio, allow_lo, allow_hi, output win_v, win_hi, win_idx);
  modport ctl (output req, prio, allow_lo, allow_hi, input win_v, win_hi, win_idx);
endinterface

//--- rtl/irq_priority_enc.sv
// Two-level priority encoder with fixed tie-break order
module irq_priority_enc (
  irq_arb_if.enc arb
);
  // High level first, then low; lowest index wins inside a level
  always_comb begin
    logic found_hi;
    logic found_lo;
    logic [3:0] idx_hi;
    logic [3:0] idx_lo;
    found_hi = 1'b0;
    found_lo = 1'b0;
    idx_hi = 4'h0;
    idx_lo = 4'h0;
    for (int i = 11; i >= 0; i--) begin
      if (arb.req[i] && arb.prio[i]) begin
        found_hi = 1'b1;
        idx_hi = 4'(i);
      end
      if (arb.req[i] && !arb.prio[i]) begin
        found_lo = 1'b1;
        idx_lo = 4'(i);
      end
    end
    arb.win_v = 1'b0;
    arb.win_hi = 1'b0;
    arb.win_idx = 4'h0;
    if (found_hi && arb.allow_hi) begin
      arb.win_v = 1'b1;
      arb.win_hi = 1'b1;
      arb.win_idx = idx_hi;
    end else if (found_lo && arb.allow_lo) begin
      arb.win_v = 1'b1;
      arb.win_idx = idx_lo;
    end
  end
endmodule

//--- rtl/mcu_interrupt_handler.sv
// Interrupt handler: pending flags, enables, priority, vector call and latency control
`include "irq_regs.svh"

// Function
// RULE_01: Pending flags are sampled and priority decoded every system clock.
// RULE_02: Fastest response is one detect clock plus four vector call clocks.
// RULE_03: A pending request after a return waits for exactly one more instruction.
// RULE_04: Worst response is eighteen clocks: detect, return, divide, vector call.
// RULE_05: Requests of equal or lower level wait until the running routine ends.
// RULE_06: Reset vector zero; sources vector from 0x0003 in 8-byte steps, fixed order.
// RULE_07: Only pin A, pin B, timer A, timer B flags clear on vectoring.
// RULE_08: Enable register: global bit 7, software flag bit 6, six source enables.
// RULE_09: Individual enables act only while the global enable is set.
// RULE_10: High level preempts low; high never preempted; ties by fixed order.
// RULE_11: Flags set regardless of enable; a flag left set requests again.
// RULE_12: Shared vector sources request when any of their flags is set.
module mcu_interrupt_handler
  import irq_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  // External pins, active low, edge sensitive
  input wire logic ext_irq_pin_a_i,
  input wire logic ext_irq_pin_b_i,
  // Same-clock flag sources
  input wire logic timer_a_overflow_i,
  input wire logic timer_b_overflow_i,
  input wire logic serial_rx_flag_i,
  input wire logic serial_tx_flag_i,
  input wire logic timer_c_high_overflow_flag_i,
  input wire logic timer_c_low_overflow_flag_i,
  input wire logic smbus_flag_i,
  input wire logic adc_window_flag_i,
  input wire logic adc_done_flag_i,
  input wire logic counter_array_overflow_flag_i,
  input wire logic counter_module_flag_i,
  input wire logic comparator_fall_flag_i,
  input wire logic comparator_rise_flag_i,
  // Priority bits of all sources and enables of sources 6 to 11
  input wire logic [11:0] src_prio_i,
  input wire logic [5:0] ext_src_en_i,
  // Instruction sequencer
  input wire logic insn_end_i,
  input wire logic return_from_isr_i,
  output logic vector_call_o,
  output logic [15:0] vector_addr_o,
  output logic [1:0] in_service_o,
  output logic [3:0] hw_flags_o,
  output logic irq_o
);

  typedef struct packed {
    logic [7:0] en;
    logic [3:0] hwf;
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic pin_a;
    logic pin_b;
    logic det_v;
    logic det_hi;
    logic [3:0] det_idx;
    ctl_state_t st;
    logic [1:0] cnt;
    logic [1:0] act;
    logic [2:0] sts;
    logic [2:0] msk;
    logic irq;
    logic [7:0] rdata;
    logic call;
    logic [15:0] addr;
  } hstate_t;

  hstate_t q;
  hstate_t d;
  irq_arb_if arb ();

  logic [11:0] pend;
  logic [11:0] src_en;
  logic [3:0] hw_set;
  logic [3:0] hw_clr;
  logic [2:0] evt;
  logic start;
  logic allowed;
  logic wr_en;
  logic wr_hwf;
  logic wr_sts_clr;
  logic wr_msk;

  irq_priority_enc u_enc (
    .arb(arb)
  );

  // Multi-flag sources fold onto their shared vector
  always_comb begin
    pend[0] = q.hwf[0];
    pend[1] = q.hwf[1];
    pend[2] = q.hwf[2];
    pend[3] = q.hwf[3];
    pend[4] = serial_rx_flag_i | serial_tx_flag_i; // RULE_12
    pend[5] = timer_c_high_overflow_flag_i | timer_c_low_overflow_flag_i; // RULE_12
    pend[6] = smbus_flag_i;
    pend[7] = adc_window_flag_i;
    pend[8] = adc_done_flag_i;
    pend[9] = counter_array_overflow_flag_i | counter_module_flag_i; // RULE_12
    pend[10] = comparator_fall_flag_i;
    pend[11] = comparator_rise_flag_i;
  end

  // Global enable overrides every individual enable
  always_comb begin
    if (q.en[`IRQ_EN_GLOBAL_BIT]) begin
      src_en = {ext_src_en_i, q.en[`IRQ_EN_SRC_MSB:0]}; // RULE_09
    end else begin
      src_en = 12'h000; // RULE_09
    end
  end

  // High in service blocks all; low in service admits only high requests
  assign arb.req = pend & src_en; // RULE_11
  assign arb.prio = src_prio_i;
  assign arb.allow_hi = !q.act[1]; // RULE_10
  assign arb.allow_lo = (q.act == 2'b00); // RULE_05

  // Register strobes, decoded by address chain
  always_comb begin
    wr_en = 1'b0;
    wr_hwf = 1'b0;
    wr_sts_clr = 1'b0;
    wr_msk = 1'b0;
    if (reg_we_i && reg_addr_i == `IRQ_EN_OFS) begin
      wr_en = 1'b1;
    end else if (reg_we_i && reg_addr_i == `IRQ_HWF_OFS) begin
      wr_hwf = 1'b1;
    end else if (reg_we_i && reg_addr_i == `IRQ_CLR_OFS) begin
      wr_sts_clr = 1'b1;
    end else if (reg_we_i && reg_addr_i == `IRQ_MSK_OFS) begin
      wr_msk = 1'b1;
    end
  end

  // The detected winner is rechecked against the current service state,
  // since a call or a return may have moved it after detection
  always_comb begin
    if (q.det_hi) begin
      allowed = !q.act[1]; // RULE_10
    end else begin
      allowed = (q.act == 2'b00); // RULE_05
    end
  end

  // A call begins only at an instruction boundary, never inside a call
  assign start = ce_i && insn_end_i && q.det_v && allowed &&
                 (q.st == ST_IDLE || q.st == ST_HOLD); // RULE_03

  // Hardware-set flags: pin edges and timer overflows
  always_comb begin
    // Falling edge read from the synchroniser alone, so no path runs through d
    hw_set[0] = q.pin_a & (q.sync_a[1] == q.sync_a[2]) & ~q.sync_a[2];
    hw_set[1] = timer_a_overflow_i;
    hw_set[2] = q.pin_b & (q.sync_b[1] == q.sync_b[2]) & ~q.sync_b[2];
    hw_set[3] = timer_b_overflow_i;
    hw_clr = 4'h0;
    if (start && q.det_idx <= `IRQ_HW_CLEARED_LAST) begin
      hw_clr[q.det_idx[1:0]] = 1'b1; // RULE_07
    end
  end

  // Events into the sticky status
  always_comb begin
    evt = 3'h0;
    evt[`IRQ_EVT_CALL_BIT] = start;
    evt[`IRQ_EVT_PREEMPT_BIT] = start && q.det_hi && q.act[0];
    evt[`IRQ_EVT_RETURN_BIT] = ce_i && return_from_isr_i && q.st == ST_IDLE;
  end

  // Next state of the whole block
  always_comb begin
    d = q;
    // Three-flop pin synchroniser; level moves when stages two and three agree
    d.sync_a = {q.sync_a[1:0], ext_irq_pin_a_i};
    d.sync_b = {q.sync_b[1:0], ext_irq_pin_b_i};
    if (q.sync_a[1] == q.sync_a[2]) begin
      d.pin_a = q.sync_a[2];
    end
    if (q.sync_b[1] == q.sync_b[2]) begin
      d.pin_b = q.sync_b[2];
    end
    // Detect stage: one clock from flag to registered winner
    d.det_v = arb.win_v; // RULE_01
    d.det_hi = arb.win_hi;
    d.det_idx = arb.win_idx;
    // Software may write the flags; a hardware set still wins
    if (wr_hwf) begin
      d.hwf = reg_wdata_i[3:0];
    end
    d.hwf = (d.hwf & ~hw_clr) | hw_set; // RULE_11
    if (wr_en) begin
      d.en = reg_wdata_i; // RULE_08
    end
    if (wr_msk) begin
      d.msk = reg_wdata_i[2:0];
    end
    // Sticky status: a new event beats a clear in the same cycle
    if (wr_sts_clr) begin
      d.sts = q.sts & ~reg_wdata_i[2:0];
    end
    d.sts = d.sts | evt;
    d.irq = |(d.sts & d.msk);
    d.call = 1'b0;
    case (q.st)
      ST_IDLE: begin
        if (start) begin
          d.st = ST_CALL;
        end else if (return_from_isr_i) begin
          // Leave the innermost level, then let one instruction run
          if (q.act[1]) begin
            d.act[1] = 1'b0; // RULE_05
          end else begin
            d.act[0] = 1'b0; // RULE_05
          end
          d.st = ST_HOLD; // RULE_03
        end
      end
      ST_CALL: begin
        d.call = 1'b1;
        if (q.cnt == 2'(`IRQ_CALL_CYCLES - 1)) begin
          d.call = 1'b0;
          d.cnt = 2'b00;
          d.st = ST_IDLE; // RULE_02
        end else begin
          d.cnt = q.cnt + 2'b01;
        end
      end
      ST_HOLD: begin
        if (start) begin
          d.st = ST_CALL; // RULE_04
        end else if (insn_end_i) begin
          d.st = ST_IDLE; // RULE_03
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
    if (start) begin
      // Four call clocks follow the detect clock
      d.call = 1'b1; // RULE_02
      d.cnt = 2'b00;
      d.addr = vector_of(q.det_idx); // RULE_06
      if (q.det_hi) begin
        d.act[1] = 1'b1; // RULE_10
      end else begin
        d.act[0] = 1'b1;
      end
    end
    // Read data stand in the cycle after the strobe; unmapped reads give zero
    d.rdata = 8'h00;
    if (reg_re_i && reg_addr_i == `IRQ_EN_OFS) begin
      d.rdata = q.en;
    end else if (reg_re_i && reg_addr_i == `IRQ_HWF_OFS) begin
      d.rdata = {2'b00, q.act, q.hwf};
    end else if (reg_re_i && reg_addr_i == `IRQ_STS_OFS) begin
      d.rdata = {5'h00, q.sts};
    end else if (reg_re_i && reg_addr_i == `IRQ_MSK_OFS) begin
      d.rdata = {5'h00, q.msk};
    end
  end

  // Single register of all state; clock enable low freezes everything except the synchronous reset
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      q.en <= `IRQ_EN_RST; // RULE_08
      q.hwf <= `IRQ_HWF_RST;
      q.sync_a <= 3'h7;
      q.sync_b <= 3'h7;
      q.pin_a <= 1'b1;
      q.pin_b <= 1'b1;
      q.det_v <= 1'b0;
      q.det_hi <= 1'b0;
      q.det_idx <= 4'h0;
      q.st <= ST_IDLE;
      q.cnt <= 2'b00;
      q.act <= 2'b00;
      q.sts <= `IRQ_EVT_RST;
      q.msk <= `IRQ_EVT_RST;
      q.irq <= 1'b0;
      q.rdata <= 8'h00;
      q.call <= 1'b0;
      q.addr <= `IRQ_RESET_VECTOR; // RULE_06
    end else if (ce_i) begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata_o = q.rdata;
  assign vector_call_o = q.call;
  assign vector_addr_o = q.addr;
  assign in_service_o = q.act;
  assign hw_flags_o = q.hwf;
  assign irq_o = q.irq;

endmodule

//--- test/irq_handler_asserts.sv
// Concurrent checks on the interrupt handler ports
`include "irq_regs.svh"
module irq_handler_asserts (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic timer_a_overflow_i,
  input wire logic insn_end_i,
  input wire logic return_from_isr_i,
  input wire logic vector_call_o,
  input wire logic [15:0] vector_addr_o,
  input wire logic [1:0] in_service_o,
  input wire logic [3:0] hw_flags_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic [7:0] en_q;
  // Shadow of the enable register, so gating can be judged from the ports alone
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) en_q <= `IRQ_EN_RST;
    else if (ce_i && reg_we_i && reg_addr_i == `IRQ_EN_OFS) en_q <= reg_wdata_i;
  end
  sequence s_call_start;
    $rose(vector_call_o);
  endsequence
  sequence s_ret_no_boundary;
    return_from_isr_i && !vector_call_o ##1 !insn_end_i;
  endsequence
  a_call_four_long: assert property (s_call_start |-> vector_call_o [*4] ##1 !vector_call_o)
    else $error("vector call not four cycles long");
  a_call_on_boundary: assert property (s_call_start |-> $past(insn_end_i))
    else $error("vector call without instruction boundary");
  a_vector_grid: assert property (vector_call_o |-> vector_addr_o >= `IRQ_VECTOR_BASE &&
    vector_addr_o <= `IRQ_VECTOR_LAST && vector_addr_o[2:0] == 3'h3) else $error("vector off grid");
  a_global_gate: assert property (s_call_start |-> $past(en_q[`IRQ_EN_GLOBAL_BIT], 2))
    else $error("call while global enable clear");
  a_hw_flag_clear: assert property ($rose(vector_call_o) && vector_addr_o == 16'h000B &&
    !$past(timer_a_overflow_i) |-> !hw_flags_o[1]) else $error("timer flag kept on vectoring");
  a_preempt_high_only: assert property ($rose(vector_call_o) && $past(in_service_o) != 2'b00
    |-> in_service_o == 2'b11) else $error("nested call not high over low");
  a_high_no_preempt: assert property (in_service_o[1] |=> !$rose(vector_call_o))
    else $error("high routine preempted");
  a_ret_one_insn: assert property (s_ret_no_boundary |=> !vector_call_o)
    else $error("call before instruction after return");
  a_enable_readback: assert property (reg_re_i && reg_addr_i == `IRQ_EN_OFS |=>
    reg_rdata_o == $past(en_q)) else $error("enable read data wrong");
  a_rdata_idle: assert property (!reg_re_i |=> reg_rdata_o == 8'h00)
    else $error("read data outside read slot");
endmodule
bind mcu_interrupt_handler irq_handler_asserts i_chk (.mclk_i, .rst_n_i, .ce_i, .reg_addr_i, .reg_wdata_i,
  .reg_we_i, .reg_re_i, .reg_rdata_o, .timer_a_overflow_i, .insn_end_i, .return_from_isr_i, .vector_call_o,
  .vector_addr_o, .in_service_o, .hw_flags_o);

//--- test/cpu_seq_model.sv
// Behavioural instruction sequencer: ends instructions and returns from routines
`include "irq_regs.svh"
module cpu_seq_model (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic call_i,
  input wire logic ret_req_i,
  input wire logic [3:0] len_i,
  output logic insn_end_o,
  output logic ret_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  // Nothing retires during a call; a return has its own fixed length
  always_ff @(posedge mclk_i) begin
    insn_end_o <= 1'b0;
    ret_o <= 1'b0;
    if (!rst_n_i || call_i) begin
      cnt_q <= 4'h1;
    end else if (cnt_q >= (ret_req_i ? 4'(`IRQ_RETURN_CYCLES) : len_i)) begin
      cnt_q <= 4'h1;
      insn_end_o <= !ret_req_i;
      ret_o <= ret_req_i;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

//--- test/tb_top.sv
// Self-checking bench for the interrupt handler
`include "irq_regs.svh"
`define CHK(nm, s, e) begin compares++; if ((s) !== (e)) begin n_fail++; $display("mismatch %s exp %h got %h", nm, e, s); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed { logic [3:0] idx; logic alt; logic [15:0] vec; } row_t;
  // Source index and flag choice beside the vector it must reach
  localparam row_t rows [15] = '{'{4'h0, 1'b0, 16'h0003}, '{4'h1, 1'b0, 16'h000B}, '{4'h2, 1'b0, 16'h0013},
    '{4'h3, 1'b0, 16'h001B}, '{4'h4, 1'b0, 16'h0023}, '{4'h5, 1'b0, 16'h002B}, '{4'h6, 1'b0, 16'h0033},
    '{4'h7, 1'b0, 16'h003B}, '{4'h8, 1'b0, 16'h0043}, '{4'h9, 1'b0, 16'h004B}, '{4'hA, 1'b0, 16'h0053},
    '{4'hB, 1'b0, 16'h005B}, '{4'h4, 1'b1, 16'h0023}, '{4'h5, 1'b1, 16'h002B}, '{4'h9, 1'b1, 16'h004B}};
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic we = 1'b0, re = 1'b0, alt = 1'b0, ret_req = 1'b0, ce = 1'b1, insn_end, ret, call, irq;
  logic [11:0] srcv = 12'h000, prio = 12'h000;
  logic [5:0] ext_en = 6'h00;
  logic [3:0] len = 4'h1, hwf;
  logic [15:0] vaddr;
  logic [1:0] insv;
  int n_fail = 0, compares = 0, k;
  always #12.5 mclk_i = ~mclk_i;
  // Pins are active low, so a set source bit pulls its pin down
  mcu_interrupt_handler i_dut (.mclk_i, .rst_n_i, .ce_i(ce), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .ext_irq_pin_a_i(~srcv[0]), .ext_irq_pin_b_i(~srcv[2]),
    .timer_a_overflow_i(srcv[1]), .timer_b_overflow_i(srcv[3]), .serial_rx_flag_i(srcv[4] & ~alt),
    .serial_tx_flag_i(srcv[4] & alt), .timer_c_high_overflow_flag_i(srcv[5] & ~alt),
    .timer_c_low_overflow_flag_i(srcv[5] & alt), .smbus_flag_i(srcv[6]), .adc_window_flag_i(srcv[7]),
    .adc_done_flag_i(srcv[8]), .counter_array_overflow_flag_i(srcv[9] & ~alt),
    .counter_module_flag_i(srcv[9] & alt), .comparator_fall_flag_i(srcv[10]),
    .comparator_rise_flag_i(srcv[11]), .src_prio_i(prio), .ext_src_en_i(ext_en), .insn_end_i(insn_end),
    .return_from_isr_i(ret), .vector_call_o(call), .vector_addr_o(vaddr), .in_service_o(insv),
    .hw_flags_o(hwf), .irq_o(irq));
  cpu_seq_model i_cpu (.mclk_i, .rst_n_i, .call_i(call), .ret_req_i(ret_req), .len_i(len),
    .insn_end_o(insn_end), .ret_o(ret));
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge mclk_i);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    addr <= a;
    re <= 1'b1;
    @(posedge mclk_i);
    re <= 1'b0;
    #1 `CHK("read data", rdata, e)
  endtask
  // Counts cycles to the call; timer pulses drop after one cycle
  task automatic wait_call();
    k = 0;
    do begin
      @(posedge mclk_i);
      srcv <= srcv & 12'hFF5;
      #1 k++;
    end while (call !== 1'b1 && k < 60);
    if (k >= 60) `CHK("call seen", 1'b0, 1'b1)
  endtask
  task automatic ret_isr();
    @(posedge mclk_i);
    ret_req <= 1'b1;
    // Look after the edge has settled, then release at the next edge
    do begin
      @(posedge mclk_i);
      #1;
    end while (ret !== 1'b1);
    @(posedge mclk_i);
    ret_req <= 1'b0;
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // The whole run needs about 500 cycles; this allows several times that
  initial begin
    #100us;
    n_fail++;
    results();
  end
  initial begin
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    tick(2);
    `CHK("reset vector", vaddr, `IRQ_RESET_VECTOR)
    rd(`IRQ_EN_OFS, `IRQ_EN_RST);
    wr(`IRQ_EN_OFS, 8'hC5);
    rd(`IRQ_EN_OFS, 8'hC5);
    rd(8'h10, 8'h00);
    $display("test reset done");
    foreach (rows[r]) begin
      wr(`IRQ_EN_OFS, rows[r].idx < 6 ? 8'h80 | (8'h01 << rows[r].idx) : 8'h80);
      @(posedge mclk_i);
      ext_en <= rows[r].idx < 6 ? 6'h00 : 6'h01 << (rows[r].idx - 4'h6);
      alt <= rows[r].alt;
      srcv <= 12'h001 << rows[r].idx;
      wait_call();
      if (rows[r].idx != 0 && rows[r].idx != 2) `CHK("latency", k, (rows[r].idx == 1 || rows[r].idx == 3) ? 3 : 2)
      `CHK("vector", vaddr, rows[r].vec)
      `CHK("in service", insv, 2'b01)
      @(posedge mclk_i);
      srcv <= 12'h000;
      ret_isr();
      tick(2);
      `CHK("hw flags", hwf, 4'h0)
    end
    $display("test table done");
    wr(`IRQ_EN_OFS, 8'h02);
    @(posedge mclk_i);
    srcv <= 12'h002;
    @(posedge mclk_i);
    srcv <= 12'h000;
    tick(20);
    `CHK("flag while off", hwf, 4'h2)
    `CHK("call while off", call, 1'b0)
    wr(`IRQ_EN_OFS, 8'h82);
    wait_call();
    `CHK("late enable vector", vaddr, 16'h000B)
    ret_isr();
    $display("test gate done");
    wr(`IRQ_EN_OFS, 8'h80);
    @(posedge mclk_i);
    ext_en <= 6'h01;
    srcv <= 12'h040;
    wait_call();
    tick(10);
    `CHK("equal level waits", call, 1'b0)
    @(posedge mclk_i);
    len <= `IRQ_DIVIDE_CYCLES;
    ret_isr();
    wait_call();
    `CHK("return then divide", k, `IRQ_DIVIDE_CYCLES)
    `CHK("flag kept vector", vaddr, 16'h0033)
    @(posedge mclk_i);
    srcv <= 12'h000;
    len <= 4'h1;
    ret_isr();
    $display("test return done");
    wr(`IRQ_CLR_OFS, 8'h07);
    wr(`IRQ_EN_OFS, 8'h8A);
    @(posedge mclk_i);
    srcv <= 12'h00A;
    wait_call();
    `CHK("tie order", vaddr, 16'h000B)
    repeat (4) @(posedge mclk_i);
    prio <= 12'h008;
    wait_call();
    `CHK("preempt vector", vaddr, 16'h001B)
    `CHK("nested service", insv, 2'b11)
    ret_isr();
    tick(1);
    `CHK("back to low", insv, 2'b01)
    ret_isr();
    tick(2);
    `CHK("flags cleared", hwf, 4'h0)
    rd(`IRQ_STS_OFS, 8'h07);
    wr(`IRQ_MSK_OFS, 8'h02);
    tick(2);
    `CHK("irq raised", irq, 1'b1)
    wr(`IRQ_MSK_OFS, 8'h00);
    tick(2);
    `CHK("irq masked", irq, 1'b0)
    wr(`IRQ_MSK_OFS, 8'h02);
    wr(`IRQ_CLR_OFS, 8'h02);
    tick(2);
    `CHK("irq cleared", irq, 1'b0)
    rd(`IRQ_STS_OFS, 8'h05);
    // Clock enable low: a write must not land
    @(posedge mclk_i);
    ce <= 1'b0;
    wr(`IRQ_EN_OFS, 8'h55);
    @(posedge mclk_i);
    ce <= 1'b1;
    rd(`IRQ_EN_OFS, 8'h8A);
    $display("test priority and status done");
    results();
  end
endmodule
